/* rtl/semf_pkg.sv */
// Constants shared by the supply event mask and flag block.
// Assumes a 24-bit register data word whose bit numbers match the register bit numbers.
package semf_pkg;

   // Register indices on the control port.
   localparam logic [1:0] SEMF_IDX_MASK = 2'h0;
   localparam logic [1:0] SEMF_IDX_FLAGS = 2'h1;

   localparam int SEMF_DATA_W = 24;

   // Mask register field positions.
   localparam int SEMF_M_BOOST_OV = 19;
   localparam int SEMF_M_BOOST_SUP_UVH = 18;
   localparam int SEMF_M_COMM_ERR = 17;
   localparam int SEMF_M_PREREG_FB_OV = 16;
   localparam int SEMF_M_BOOST_OUT_UVH = 15;
   localparam int SEMF_M_SUP_LOWEST_UV = 14;
   localparam int SEMF_M_PREREG_UVH = 12;
   localparam int SEMF_M_SUP_UVL = 11;
   localparam int SEMF_M_SUP_UVH = 10;
   localparam int SEMF_M_WAKE_A = 9;
   localparam int SEMF_M_WAKE_B = 8;

   // Flag register field positions.
   localparam int SEMF_F_BOOST_SUP_UVH = 23;
   localparam int SEMF_F_BOOST_OUT_UVH = 22;
   localparam int SEMF_F_OC_HI = 21;
   localparam int SEMF_F_OC_LO = 16;
   localparam int SEMF_F_CLK_OK = 15;
   localparam int SEMF_F_BOOST_OV = 14;
   localparam int SEMF_F_OT_HI = 13;
   localparam int SEMF_F_OT_LO = 8;

   // Writable and sticky bit sets, and reset values.
   localparam logic [23:0] SEMF_MASK_WR = 24'h0FDF00;
   localparam logic [23:0] SEMF_MASK_RST = 24'h000000;
   localparam logic [23:0] SEMF_FLAG_STICKY = 24'hFF7F00;
   localparam logic [23:0] SEMF_FLAG_RST = 24'hC00000;

   // Position of each detector input in the synchronised condition vector.
   localparam int SEMF_C_OT_LO = 0;
   localparam int SEMF_C_OC_LO = 6;
   localparam int SEMF_C_BOOST_SUP_UVH = 12;
   localparam int SEMF_C_BOOST_OUT_UVH = 13;
   localparam int SEMF_C_BOOST_OV = 14;
   localparam int SEMF_C_PREREG_FB_OV = 15;
   localparam int SEMF_C_SUP_LOWEST_UV = 16;
   localparam int SEMF_C_PREREG_UVH = 17;
   localparam int SEMF_C_SUP_UVL = 18;
   localparam int SEMF_C_SUP_UVH = 19;
   localparam int SEMF_C_COMM_ERR = 20;
   localparam int SEMF_C_WAKE_A = 21;
   localparam int SEMF_C_WAKE_B = 22;
   localparam int SEMF_C_CLK_OK = 23;
   localparam int SEMF_COND_W = 24;

endpackage

/* rtl/semf_sticky_flag.sv */
// One sticky event flag with write-one-to-clear.
// Assumes set and clear are single-cycle terms on sys_clk.
`timescale 1ns/100ps
module semf_sticky_flag #(
   parameter logic RESET_VAL = 1'b0
) (
   // Clock and reset.
   input wire logic sys_clk,
   input wire logic rst,
   // Control.
   input wire logic setEv,
   input wire logic clrEv,
   output logic flag_r
);

   logic flag_nxt;

   // A set in the same cycle as a clear wins, so no event is lost.
   assign flag_nxt = setEv | (flag_r & ~clrEv);

   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         flag_r <= RESET_VAL;
      end
      else
      begin
         flag_r <= flag_nxt;
      end
   end

endmodule

/* rtl/semf_supply_event_mask_and_flags.sv */
// Interrupt mask and sticky event flag registers for supply-monitor events.
// Assumes detector inputs are asynchronous levels and the serial interface logic
// presents single-cycle register read and write strobes on sys_clk.
//
// Overview of operation
// - Mask bit 19 set blocks interrupts on any boost overvoltage transition; resets 0.
// - Mask bit 18 set blocks interrupts on any boost-supply undervoltage-high transition.
// - Mask bit 17 set blocks interrupts on any communication error transition.
// - Mask bits 9 and 8 block interrupts on wake input A and B transitions.
// - Mask bit 16 set blocks the pre-regulator feedback overvoltage interrupt.
// - Mask bit 15 set blocks the boost-output undervoltage-high interrupt.
// - Mask bit 14 set blocks the lowest-threshold supply undervoltage interrupt.
// - Mask bit 11 set blocks the supply undervoltage-low interrupt.
// - Mask bit 12 blocks pre-regulator, bit 10 supply undervoltage-high interrupts.
// - Sticky flags read 1 after their event; cleared only by writing 1, or by reset except bits 23 and 22.
// - Flag bit 23 records boost-supply undervoltage-high; resets to 1.
// - Flag bit 22 records boost-output undervoltage-high; resets to 1.
// - Flag bits 21..16 record six regulator overcurrent events; reset 0.
// - Flag bit 14 records boost-output overvoltage protection; resets 0.
// - Flag bits 13..8 record six overtemperature shutdown events; reset 0.
// - Flag bit 15 shows live external clock divider window status; read only.
`timescale 1ns/100ps
module semf_supply_event_mask_and_flags
   import semf_pkg::*;
(
   // Clock and reset.
   input wire logic sys_clk,
   input wire logic rst,
   // Register access from the serial control interface.
   input wire logic [1:0] regAddr,
   input wire logic regWr,
   input wire logic regRd,
   input wire logic [23:0] regWrData,
   output logic [23:0] regRdData_r,
   output logic regRdValid_r,
   // Supply detector levels, asynchronous.
   input wire logic boostSupplyUvh,
   input wire logic boostOutUvh,
   input wire logic boostOverVolt,
   input wire logic preregFbOv,
   input wire logic supplyLowestUv,
   input wire logic preregUvh,
   input wire logic supplyUvl,
   input wire logic supplyUvh,
   // Overcurrent: prereg, buck a, b, c, linreg a, b from bit 5 down.
   input wire logic [5:0] overCurrent,
   // Overtemperature: boost, buck a, b, c, linreg a, b from bit 5 down.
   input wire logic [5:0] overTemp,
   // Other sources, asynchronous.
   input wire logic commError,
   input wire logic wakeInA,
   input wire logic wakeInB,
   input wire logic extClockInWindow,
   // Interrupt request, high for one cycle per cycle with any unmasked event; events in the same cycle share it.
   output logic irqReq_r
);

   logic [SEMF_COND_W-1:0] condRaw;
   logic [SEMF_COND_W-1:0] cond;
   logic [SEMF_COND_W-1:0] condPrev_r;
   logic [SEMF_COND_W-1:0] condRise;
   logic [SEMF_COND_W-1:0] condToggle;
   logic [23:0] mask_r;
   logic [23:0] mask_nxt;
   logic [23:0] flags;
   logic [23:0] flagSet;
   logic [23:0] flagClr;
   logic [23:0] irqSrc;
   logic [23:0] rdMux;
   logic irqReq_nxt;
   logic wrMask;
   logic wrFlags;
   logic selMask;
   logic selFlags;

   assign condRaw = {
      extClockInWindow,
      wakeInB,
      wakeInA,
      commError,
      supplyUvh,
      supplyUvl,
      preregUvh,
      supplyLowestUv,
      preregFbOv,
      boostOverVolt,
      boostOutUvh,
      boostSupplyUvh,
      overCurrent,
      overTemp
   };

   semf_sync #(
      .WIDTH(SEMF_COND_W)
   ) u_sync (
      .sys_clk(sys_clk),
      .rst(rst),
      .asyncIn(condRaw),
      .syncOut(cond)
   );

   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         condPrev_r <= '0;
      end
      else
      begin
         condPrev_r <= cond;
      end
   end

   assign condRise = cond & ~condPrev_r;
   assign condToggle = cond ^ condPrev_r;

   // Address decode.
   assign selMask = (regAddr == SEMF_IDX_MASK);
   assign selFlags = (regAddr == SEMF_IDX_FLAGS);
   assign wrMask = regWr & selMask;
   assign wrFlags = regWr & selFlags;

   assign mask_nxt = wrMask ? (regWrData & SEMF_MASK_WR) : mask_r;

   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         mask_r <= SEMF_MASK_RST;
      end
      else
      begin
         mask_r <= mask_nxt;
      end
   end

   assign flagSet[SEMF_F_BOOST_SUP_UVH] = condRise[SEMF_C_BOOST_SUP_UVH];
   assign flagSet[SEMF_F_BOOST_OUT_UVH] = condRise[SEMF_C_BOOST_OUT_UVH];
   assign flagSet[SEMF_F_OC_HI:SEMF_F_OC_LO] = condRise[SEMF_C_OC_LO +: 6];
   assign flagSet[SEMF_F_CLK_OK] = 1'b0;
   assign flagSet[SEMF_F_BOOST_OV] = condRise[SEMF_C_BOOST_OV];
   assign flagSet[SEMF_F_OT_HI:SEMF_F_OT_LO] = condRise[SEMF_C_OT_LO +: 6];
   assign flagSet[7:0] = 8'h00;

   assign flagClr = wrFlags ? (regWrData & SEMF_FLAG_STICKY) : 24'h000000;

   genvar gi;
   generate
      for (gi = 0; gi < 24; gi++)
      begin : g_flag
         if (SEMF_FLAG_STICKY[gi])
         begin : g_sticky
            semf_sticky_flag #(
               .RESET_VAL(SEMF_FLAG_RST[gi])
            ) u_flag (
               .sys_clk(sys_clk),
               .rst(rst),
               .setEv(flagSet[gi]),
               .clrEv(flagClr[gi]),
               .flag_r(flags[gi])
            );
         end
         else if (gi == SEMF_F_CLK_OK)
         begin : g_live
            assign flags[gi] = cond[SEMF_C_CLK_OK];
         end
         else
         begin : g_zero
            assign flags[gi] = 1'b0;
         end
      end
   endgenerate

   assign irqSrc[SEMF_M_BOOST_OV] = condToggle[SEMF_C_BOOST_OV];
   assign irqSrc[SEMF_M_BOOST_SUP_UVH] = condToggle[SEMF_C_BOOST_SUP_UVH];
   assign irqSrc[SEMF_M_COMM_ERR] = condToggle[SEMF_C_COMM_ERR];
   assign irqSrc[SEMF_M_PREREG_FB_OV] = condRise[SEMF_C_PREREG_FB_OV];
   assign irqSrc[SEMF_M_BOOST_OUT_UVH] = condRise[SEMF_C_BOOST_OUT_UVH];
   assign irqSrc[SEMF_M_SUP_LOWEST_UV] = condRise[SEMF_C_SUP_LOWEST_UV];
   assign irqSrc[SEMF_M_PREREG_UVH] = condRise[SEMF_C_PREREG_UVH];
   assign irqSrc[SEMF_M_SUP_UVL] = condRise[SEMF_C_SUP_UVL];
   assign irqSrc[SEMF_M_SUP_UVH] = condRise[SEMF_C_SUP_UVH];
   assign irqSrc[SEMF_M_WAKE_A] = condToggle[SEMF_C_WAKE_A];
   assign irqSrc[SEMF_M_WAKE_B] = condToggle[SEMF_C_WAKE_B];
   assign irqSrc[23:20] = 4'h0;
   assign irqSrc[13] = 1'b0;
   assign irqSrc[7:0] = 8'h00;

   assign irqReq_nxt = |(irqSrc & ~mask_r);

   // Read data; unmapped indices read zero.
   assign rdMux = selMask ? mask_r : (selFlags ? flags : 24'h000000);

   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         irqReq_r <= 1'b0;
         regRdData_r <= 24'h000000;
         regRdValid_r <= 1'b0;
      end
      else
      begin
         irqReq_r <= irqReq_nxt;
         regRdValid_r <= regRd;
         if (regRd)
         begin
            regRdData_r <= rdMux;
         end
      end
   end

endmodule

/* rtl/semf_sync.sv */
// Two-stage synchroniser for a vector of asynchronous levels.
// Assumes each bit is an independent level; no bus coherence is needed.
`timescale 1ns/100ps
module semf_sync #(
   parameter int WIDTH = 1
) (
   // Clock and reset.
   input wire logic sys_clk,
   input wire logic rst,
   // Levels.
   input wire logic [WIDTH-1:0] asyncIn,
   output logic [WIDTH-1:0] syncOut
);

   logic [WIDTH-1:0] stage1_r;

   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         stage1_r <= '0;
         syncOut <= '0;
      end
      else
      begin
         stage1_r <= asyncIn;
         syncOut <= stage1_r;
      end
   end

endmodule

/* testbench/semf_check_props.sv */
// Port checker for the supply event mask and flag block.
// Assumes it is bound to the block's top module.
`timescale 1ns/100ps
module semf_check
   import semf_pkg::*;
(
   // Clock and reset.
   input wire logic sys_clk,
   input wire logic rst,
   // Register port.
   input wire logic [1:0] regAddr,
   input wire logic regWr,
   input wire logic regRd,
   input wire logic [23:0] regWrData,
   input wire logic [23:0] regRdData_r,
   input wire logic regRdValid_r,
   // Status.
   input wire logic extClockInWindow,
   input wire logic irqReq_r
);
   logic [23:0] maskSh_r;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (rst);
   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         maskSh_r <= SEMF_MASK_RST;
      end
      else if (regWr && regAddr == SEMF_IDX_MASK)
      begin
         maskSh_r <= regWrData & SEMF_MASK_WR;
      end
   end
   read_answer_a: assert property (regRd |=> regRdValid_r)
      else $error("read strobe got no valid pulse");
   valid_cause_a: assert property (regRdValid_r |-> $past(regRd))
      else $error("valid pulse without read");
   reset_quiet_a: assert property ($fell(rst) |-> !irqReq_r && regRdData_r == 24'h0)
      else $error("outputs not quiet after reset");
   unmapped_zero_a: assert property (regRd && regAddr[1] |=> regRdData_r == 24'h0)
      else $error("unmapped read not zero");
   mask_reserved_a: assert property (regRd && regAddr == SEMF_IDX_MASK |=>
      (regRdData_r & ~SEMF_MASK_WR) == 24'h0)
      else $error("reserved mask bits not zero");
   mask_readback_a: assert property (regRd && regAddr == SEMF_IDX_MASK |=>
      regRdData_r == $past(maskSh_r))
      else $error("mask readback wrong");
   clock_window_a: assert property (regRd && regAddr == SEMF_IDX_FLAGS
      && $stable(extClockInWindow) && extClockInWindow == $past(extClockInWindow, 3) |=>
      regRdData_r[15] == $past(extClockInWindow))
      else $error("clock window bit wrong");
   full_mask_a: assert property ((maskSh_r == SEMF_MASK_WR)[*4] |-> !irqReq_r)
      else $error("irq while all sources masked");
   data_hold_a: assert property (!regRd |=> $stable(regRdData_r))
      else $error("read data moved without read");
   irq_seen_c: cover property (irqReq_r);
   flag_read_c: cover property (regRd && regAddr == SEMF_IDX_FLAGS);
   full_mask_c: cover property ((maskSh_r == SEMF_MASK_WR)[*4]);
endmodule

bind semf_supply_event_mask_and_flags semf_check u_chk (.sys_clk(sys_clk), .rst(rst),
   .regAddr(regAddr), .regWr(regWr), .regRd(regRd), .regWrData(regWrData),
   .regRdData_r(regRdData_r), .regRdValid_r(regRdValid_r),
   .extClockInWindow(extClockInWindow), .irqReq_r(irqReq_r));

/* testbench/tb_top.sv */
// Self-checking bench for the supply event mask and flag block.
// Assumes the checker file binds itself to the block.
`timescale 1ns/100ps
module tb_top;
   import semf_pkg::*;
   logic sys_clk = 1'b0;
   logic rst = 1'b1;
   logic [1:0] regAddr = 2'h0;
   logic regWr = 1'b0;
   logic regRd = 1'b0;
   logic [23:0] regWrData = 24'h000000;
   logic [23:0] regRdData_r;
   logic regRdValid_r;
   logic irqReq_r;
   logic [10:0] det = 11'h000;
   logic [5:0] overCurrent = 6'h00;
   logic [5:0] overTemp = 6'h00;
   logic extClockInWindow = 1'b0;
   logic [23:0] expQ[$];
   logic [23:0] fexp;
   logic [31:0] seed = 32'hDA2F;
   int error_cnt = 0;
   int check_count = 0;
   int irqN = 0;
   // Mask bit of each detector in det order; anyEdge marks sources that fire on both edges.
   int mb[11] = '{18, 15, 19, 16, 14, 12, 11, 10, 17, 9, 8};
   localparam logic [10:0] anyEdge = 11'h705;
   semf_supply_event_mask_and_flags DUT (.sys_clk(sys_clk), .rst(rst), .regAddr(regAddr),
      .regWr(regWr), .regRd(regRd), .regWrData(regWrData), .regRdData_r(regRdData_r),
      .regRdValid_r(regRdValid_r), .boostSupplyUvh(det[0]), .boostOutUvh(det[1]),
      .boostOverVolt(det[2]), .preregFbOv(det[3]), .supplyLowestUv(det[4]),
      .preregUvh(det[5]), .supplyUvl(det[6]), .supplyUvh(det[7]), .commError(det[8]),
      .wakeInA(det[9]), .wakeInB(det[10]), .overCurrent(overCurrent), .overTemp(overTemp),
      .extClockInWindow(extClockInWindow), .irqReq_r(irqReq_r));
   initial
   begin
      forever #12.5 sys_clk = ~sys_clk;
   end
   function automatic logic [31:0] xs(input logic [31:0] s);
      s = s ^ (s << 13);
      s = s ^ (s >> 17);
      return s ^ (s << 5);
   endfunction
   task automatic chk(input string name, input logic [23:0] got, input logic [23:0] exp);
      check_count++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("BAD %s exp %h got %h", name, exp, got);
      end
   endtask
   task automatic wr(input logic [1:0] a, input logic [23:0] d);
      @(negedge sys_clk);
      regAddr = a;
      regWrData = d;
      regWr = 1'b1;
      @(negedge sys_clk);
      regWr = 1'b0;
   endtask
   task automatic rd(input logic [1:0] a, input logic [23:0] e);
      @(negedge sys_clk);
      regAddr = a;
      regRd = 1'b1;
      expQ.push_back(e);
      @(negedge sys_clk);
      regRd = 1'b0;
   endtask
   task automatic src(input int i, input bit m);
      wr(SEMF_IDX_MASK, m ? (24'h1 << mb[i]) : (SEMF_MASK_WR & ~(24'h1 << mb[i])));
      irqN = 0;
      det[i] = 1'b1;
      repeat (6) @(negedge sys_clk);
      chk("irq on rise", 24'(irqN), {23'h0, !m});
      irqN = 0;
      det[i] = 1'b0;
      repeat (6) @(negedge sys_clk);
      chk("irq on fall", 24'(irqN), {23'h0, !m && anyEdge[i]});
   endtask
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   always @(negedge sys_clk)
   begin
      if (regRdValid_r === 1'b1)
         chk("read data", regRdData_r, expQ.pop_front());
      if (irqReq_r === 1'b1)
         irqN++;
   end
   initial
   begin
      #(25 * 4000);
      error_cnt++;
      wrap_up();
   end
   initial
   begin
      repeat (6) @(negedge sys_clk);
      rst = 1'b0;
      rd(SEMF_IDX_MASK, SEMF_MASK_RST);
      rd(SEMF_IDX_FLAGS, SEMF_FLAG_RST);
      wr(SEMF_IDX_FLAGS, 24'hFFFFFF);
      rd(SEMF_IDX_FLAGS, 24'h000000);
      wr(SEMF_IDX_MASK, 24'hFFFFFF);
      rd(SEMF_IDX_MASK, SEMF_MASK_WR);
      wr(2'h3, 24'h000000);
      rd(SEMF_IDX_MASK, SEMF_MASK_WR);
      rd(2'h2, 24'h000000);
      $display("test reset and registers done");
      for (int i = 0; i < 11; i++)
      begin
         src(i, 1'b0);
         src(i, 1'b1);
      end
      rd(SEMF_IDX_FLAGS, 24'hC04000);
      $display("test interrupts done");
      for (int k = 0; k < 4; k++)
      begin
         seed = xs(seed);
         extClockInWindow = seed[12];
         wr(SEMF_IDX_FLAGS, 24'hFFFFFF);
         overCurrent = seed[5:0];
         overTemp = seed[11:6];
         fexp = {2'b00, seed[5:0], seed[12], 1'b0, seed[11:6], 8'h00};
         repeat (6) @(negedge sys_clk);
         rd(SEMF_IDX_FLAGS, fexp);
         wr(SEMF_IDX_FLAGS, 24'h000000);
         overCurrent = 6'h00;
         overTemp = 6'h00;
         repeat (6) @(negedge sys_clk);
         rd(SEMF_IDX_FLAGS, fexp);
      end
      wr(SEMF_IDX_FLAGS, 24'hFFFFFF);
      rd(SEMF_IDX_FLAGS, {8'h00, extClockInWindow, 15'h0000});
      $display("test flags done");
      // A second reset must restore the mask and the two set-at-reset flags.
      extClockInWindow = 1'b0;
      rst = 1'b1;
      repeat (3) @(negedge sys_clk);
      rst = 1'b0;
      rd(SEMF_IDX_MASK, SEMF_MASK_RST);
      rd(SEMF_IDX_FLAGS, SEMF_FLAG_RST);
      $display("test second reset done");
      repeat (3) @(negedge sys_clk);
      chk("reads pending", 24'(expQ.size()), 24'h000000);
      wrap_up();
   end
endmodule
